// ===== bench/usart_data_and_timing_regs_tb_top.sv
`timescale 1ns/1ps
module usart_data_and_timing_regs_tb_top;
  logic clk, rst, wr, rd, iso_error;
  logic sck_pin = 1'b0;
  logic [7:0] addr, ir_filter;
  logic [31:0] wdata, rdata, v, d;
  logic [3:0] ln, pv;
  logic [2:0] sc = 3'h0;
  logic [8:0] tx_char, rx_char;
  logic tx_as_command, tx_go, tx_holding_free, rx_has_char, rx_timeout;
  logic guard_active, sample_tick, bit_tick, irq, rx_strobe, rx_is_command;
  logic tx_take, tx_char_done;
  logic [9:0] exp_q[$];
  int failures = 0, cmp_count = 0, seed = 25037, i, k, c;
  int ad[5] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h24};
  int mk[5] = '{32'h7ffff, 32'hffff, 32'hff, 32'h7ff, 32'hff};
  int bd[6] = '{8'h05, 32'h40005, 8'h02, 8'h02, 8'h01, 8'h00};
  int md[6] = '{8'h09, 8'h09, 8'h08, 8'h0a, 8'h0c, 8'h09};
  int nn[6] = '{4, 8, 2, 2, 2, 1};
  int ex[6] = '{20, 44, 64, 32, 32, -1};
  usd_regs dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .bell_line(ln[0]), .set_ready_line(ln[1]), .carrier_line(ln[2]),
    .send_clear_line(ln[3]), .sck_pin, .rx_strobe, .rx_char, .rx_is_command,
    .tx_take, .tx_char_done, .iso_error, .tx_char, .tx_as_command, .tx_go,
    .tx_holding_free, .rx_has_char, .rx_timeout, .guard_active, .sample_tick,
    .bit_tick, .ir_filter, .irq);
  usd_peer peer (.clk, .tx_go, .bit_tick, .tx_char, .tx_as_command,
    .tx_take, .tx_char_done, .rx_strobe, .rx_char, .rx_is_command);
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The card clock runs free at one eighth of the system clock.
  always @(posedge clk)
  begin
    sc <= sc + 3'h1;
    sck_pin <= sc[2];
  end
  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (e !== g)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task chb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task wr_(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rd_(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task wt(input logic s);
    int g;
    for (g = 0; g < 500 && (s ? tx_char_done : tx_take) !== 1'b1; g++)
      @(posedge clk) #1;
    if (g == 500)
    begin
      failures++;
      close_out;
    end
  endtask
  task tx_put;
    d = $random(seed) & 32'h81ff;
    exp_q.push_back({d[15], d[8:0]});
    wr_(8'h0c, d);
    chb("tx free", 1'b0, tx_holding_free);
  endtask
  task meas(input int n, output int r);
    int t, g;
    t = 0;
    r = 0;
    for (g = 0; g < 3000 && t <= n; g++)
    begin
      @(posedge clk) #1;
      if (t > 0) r++;
      if (bit_tick === 1'b1) t++;
    end
    if (t <= n) r = -1;
  endtask
  initial
  begin
    {rst, wr, rd, iso_error, ln, addr, wdata} = {1'b1, 47'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_(8'h1c);
    chk("ratio reset", 32'h174, v);
    for (i = 0; i < 5; i++)
    begin
      d = $random(seed);
      wr_(8'(ad[i]), d);
      rd_(8'(ad[i]));
      chk("rw reg", d & mk[i], v);
    end
    chk("ir filter", {24'h0, d[7:0]}, {24'h0, ir_filter});
    rd_(8'h3c);
    chk("unmapped", 32'h0, v);
    rd_(8'h0c);
    chk("tx read", 32'h0, v);
    rd_(8'h04);
    pv = ln;
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk) ln <= 4'($random(seed));
      repeat (5) @(posedge clk);
      rd_(8'h04);
      chk("modem", {25'h0, ln, ln[3:1] ^ pv[3:1]},
          (v & 32'hfe0000) >> 17);
      rd_(8'h04);
      chk("modem", {25'h0, ln, 3'h0}, (v & 32'hfe0000) >> 17);
      pv = ln;
    end
    wr_(8'h00, 32'h9);
    // A zero divisor empties the counter, so the new one applies at once.
    wr_(8'h10, 32'h0);
    wr_(8'h10, 32'h3);
    wr_(8'h18, 32'h3);
    wr_(8'h14, 32'h2);
    d = $random(seed) & 32'h81ff;
    peer.send(d[8:0], d[15]);
    chb("rx has", 1'b1, rx_has_char);
    rd_(8'h08);
    chk("rx holding", d, v);
    chb("rx has", 1'b0, rx_has_char);
    // Let the first character's time-out pass, then clear its status.
    repeat (12) @(posedge clk);
    wr_(8'h30, 32'h4);
    peer.send(9'h0, 1'b0);
    k = 0;
    for (c = 0; c < 300 && rx_timeout !== 1'b1; c++)
    begin
      if (bit_tick === 1'b1) k++;
      @(posedge clk) #1;
    end
    chk("timeout ticks", 2, k);
    k = 0;
    repeat (30)
    begin
      @(posedge clk) #1;
      if (sample_tick === 1'b1) k++;
    end
    chk("sample ticks", 10, k);
    wr_(8'h2c, 32'h4);
    chb("irq", 1'b1, irq);
    wr_(8'h2c, 32'h0);
    chb("irq", 1'b0, irq);
    wr_(8'h2c, 32'h4);
    wr_(8'h30, 32'h4);
    chb("irq", 1'b0, irq);
    peer.slow = 4;
    chb("tx free", 1'b1, tx_holding_free);
    tx_put;
    wt(0);
    tx_put;
    wt(1);
    k = 0;
    @(posedge clk) #1;
    for (c = 0; c < 100 && guard_active === 1'b1; c++)
    begin
      if (bit_tick === 1'b1) k++;
      @(posedge clk) #1;
    end
    if (c == 100) failures++;
    chk("guard ticks", 3, k);
    wt(0);
    for (i = 0; i < 2; i++)
      chk("tx sent", {22'h0, exp_q[i]}, {22'h0, peer.sent_q[i]});
    wr_(8'h00, 32'h4);
    @(posedge clk) iso_error <= 1'b1;
    repeat (3) @(posedge clk);
    iso_error <= 1'b0;
    rd_(8'h20);
    chk("errors", 32'h3, v);
    rd_(8'h20);
    chk("errors", 32'h0, v);
    wr_(8'h1c, 32'h2);
    for (i = 0; i < 6; i++)
    begin
      wr_(8'h10, bd[i]);
      wr_(8'h00, md[i]);
      meas(1, c);
      meas(nn[i], c);
      chk("bit period", ex[i], c);
    end
    wr_(8'h1c, 32'h0);
    wr_(8'h10, 32'h1);
    wr_(8'h00, 32'hc);
    meas(1, c);
    chk("ratio zero", -1, c);
    close_out;
  end
endmodule

// ===== bench/usd_peer.sv
`timescale 1ns/1ps
module usd_peer (
  input wire logic clk,
  input wire logic tx_go,
  input wire logic bit_tick,
  input wire logic [8:0] tx_char,
  input wire logic tx_as_command,
  output logic tx_take,
  output logic tx_char_done,
  output logic rx_strobe,
  output logic [8:0] rx_char,
  output logic rx_is_command
);
  logic [9:0] sent_q[$];
  int slow = 1;
  int busy = 0;
  initial
  begin
    tx_take = 1'b0;
    tx_char_done = 1'b0;
    rx_strobe = 1'b0;
    rx_char = 9'h0;
    rx_is_command = 1'b0;
  end
  // A taken character keeps the shifter busy for slow bit periods.
  always @(posedge clk)
  begin
    tx_take <= 1'b0;
    tx_char_done <= 1'b0;
    if (busy == 0 && tx_go === 1'b1 && !tx_take)
    begin
      tx_take <= 1'b1;
      sent_q.push_back({tx_as_command, tx_char});
      busy <= slow;
    end
    else if (busy > 0 && bit_tick === 1'b1)
    begin
      busy <= busy - 1;
      tx_char_done <= busy == 1;
    end
  end
  task send(input logic [8:0] c, input logic k);
    @(posedge clk);
    rx_char <= c;
    rx_is_command <= k;
    rx_strobe <= 1'b1;
    @(posedge clk);
    rx_strobe <= 1'b0;
    // Lines carry no meaning outside the strobe, so they stop showing it.
    rx_char <= ~c;
    rx_is_command <= ~k;
    #1;
  endtask
endmodule

// ===== bench/usd_regs_props.sv
`timescale 1ns/1ps
module usd_regs_props #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic rx_strobe,
  input wire logic [8:0] rx_char,
  input wire logic rx_is_command,
  input wire logic rx_has_char,
  input wire logic tx_take,
  input wire logic tx_holding_free,
  input wire logic tx_go,
  input wire logic guard_active,
  input wire logic bit_tick,
  input wire logic tx_char_done,
  input wire logic iso_error
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_rx;
    rx_strobe ##1 !rx_strobe ##1 (rd && addr == 8'h08 && !rx_strobe);
  endsequence
  sequence s_nrd;
    rd && addr == 8'h20 && !iso_error;
  endsequence
  property p_rx_set;
    rx_strobe |=> rx_has_char;
  endproperty
  property p_rx_clr;
    rd && addr == 8'h08 && !rx_strobe |=> !rx_has_char;
  endproperty
  property p_rhr;
    s_rx |=> rdata[8:0] == $past(rx_char, 3)
      && rdata[15] == $past(rx_is_command, 3);
  endproperty
  property p_busy;
    wr && addr == 8'h0c && !tx_take |=> !tx_holding_free;
  endproperty
  property p_free;
    tx_take && !wr && !$past(wr) |=> tx_holding_free;
  endproperty
  property p_guard;
    guard_active && !tx_char_done && !bit_tick |=> guard_active;
  endproperty
  property p_nerr;
    s_nrd ##1 !iso_error ##1 s_nrd |=> rdata == 32'h0;
  endproperty
  property p_idle;
    !rd |=> rdata == 32'h0;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("rx flag not set");
  a_rx_clr: assert property (p_rx_clr) else $error("rx flag kept");
  a_rhr: assert property (p_rhr) else $error("rx holding wrong");
  a_busy: assert property (p_busy) else $error("tx free after write");
  a_free: assert property (p_free) else $error("tx not free");
  a_guard: assert property (p_guard) else $error("guard ended early");
  a_nerr: assert property (p_nerr) else $error("count not cleared");
  a_idle: assert property (p_idle) else $error("read data not idle");
endmodule

bind usd_regs usd_regs_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ===== src/usd_map.svh
// Behaviour
// - Toggle on set-ready, carrier or send-clear sets a change flag; status read clears.
// - Channel status shows live levels of bell, set-ready, carrier and send-clear lines.
// - Receive holding returns the last received character in bits 8 to 0.
// - Receive holding bit 15 marks the last character as data or command.
// - Transmit holding write becomes the next character after the one shifting out.
// - Transmit holding bit 15 selects data sync or command sync delimiter.
// - Async bit rate is clock over 16 or 8 and over the divisor.
// - Sync bit rate is clock over divisor with no oversampling.
// - Smart-card bit rate is serial clock pin rising edges over divisor and over the clock ratio.
// - Fraction 0 disables fractional division; 1 to 7 add eighths to divisor.
// - Idle limit 0 disables time-out; otherwise delay is limit bit periods.
// - Guard 0 disables; otherwise that many idle bit periods between characters.
// - Clock ratio 0 stops smart-card bit clock; resets to 0x174.
// - Smart-card errors counted in eight bits; reading the count clears it.
// - Eight-bit read-write infrared filter setting drives the demodulator filter.
// - Receive-ready sets on a complete character; cleared by reading receive holding.
// - Transmit-free is high when holding empty, low if pending or disabled.
`ifndef USD_MAP_SVH
`define USD_MAP_SVH
`define USD_OFS_MODE 8'h00
`define USD_OFS_CHAN 8'h04
`define USD_OFS_RXH 8'h08
`define USD_OFS_TXH 8'h0c
`define USD_OFS_BAUD 8'h10
`define USD_OFS_IDLE 8'h14
`define USD_OFS_GUARD 8'h18
`define USD_OFS_RATIO 8'h1c
`define USD_OFS_NERR 8'h20
`define USD_OFS_IRF 8'h24
`define USD_OFS_ISTS 8'h28
`define USD_OFS_IEN 8'h2c
`define USD_OFS_ICLR 8'h30
`define USD_MODE_SYNC 0
`define USD_MODE_OVER 1
`define USD_MODE_ISO 2
`define USD_MODE_TXEN 3
`define USD_CMD_BIT 15
`define USD_FP_LSB 16
`define USD_CHG_LSB 17
`define USD_IMG_LSB 20
`define USD_TO_BIT 8
`define USD_RATIO_RST 11'h174
`define USD_OS16 4'hf
`define USD_OS8 4'h7
`define USD_IRQ_RX 0
`define USD_IRQ_TX 1
`define USD_IRQ_TO 2
`define USD_IRQ_CHG 3
`define USD_IRQ_ERR 4
`endif

// ===== src/usd_pkg.sv
package usd_pkg;
  typedef struct packed {
    logic [3:0] ln1;
    logic [3:0] ln2;
    logic [3:0] lnp;
    logic sck1;
    logic sck2;
    logic sckp;
    logic [3:0] mode;
    logic [2:0] chg;
    logic [8:0] rx_chr;
    logic rx_cmd;
    logic rx_has;
    logic [8:0] tx_chr;
    logic tx_cmd;
    logic tx_pend;
    logic [15:0] cd;
    logic [2:0] fp;
    logic [15:0] div_cnt;
    logic [2:0] acc;
    logic [3:0] os_cnt;
    logic [10:0] rat_cnt;
    logic os_tick;
    logic bit_tick;
    logic [15:0] to_lim;
    logic [15:0] to_cnt;
    logic to_run;
    logic [7:0] tg;
    logic [7:0] tg_cnt;
    logic [10:0] ratio;
    logic [7:0] nerr;
    logic [7:0] irf;
    logic [4:0] ists;
    logic [4:0] ien;
    logic [31:0] rdata;
  } usd_state_t;
endpackage

// ===== src/usd_regs.sv
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`include "usd_map.svh"
module usd_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic bell_line,
  input wire logic set_ready_line,
  input wire logic carrier_line,
  input wire logic send_clear_line,
  input wire logic sck_pin,
  input wire logic rx_strobe,
  input wire logic [8:0] rx_char,
  input wire logic rx_is_command,
  input wire logic tx_take,
  input wire logic tx_char_done,
  input wire logic iso_error,
  output logic [8:0] tx_char,
  output logic tx_as_command,
  output logic tx_go,
  output logic tx_holding_free,
  output logic rx_has_char,
  output logic rx_timeout,
  output logic guard_active,
  output logic sample_tick,
  output logic bit_tick,
  output logic [7:0] ir_filter,
  output logic irq
);

  generate
    if (ADDR_W < 6)
    begin : g_chk
      $error("usd_regs needs ADDR_W of at least 6");
    end
  endgenerate

  usd_pkg::usd_state_t s_r;
  usd_pkg::usd_state_t s_nxt;

  // Hardware set always beats a clear in the same cycle.
  function automatic logic sticky(input logic q, input logic set,
                                  input logic clr);
    sticky = set | (q & ~clr);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  logic rd_chan;
  logic rd_rxh;
  logic rd_nerr;
  logic wr_txh;
  logic [2:0] toggles;
  logic src_edge;
  logic div_end;
  logic [3:0] frac_sum;
  logic os_top_hit;
  logic [3:0] os_top;
  logic [4:0] events;
  logic to_hit;

  always_comb
  begin
    s_nxt = s_r;
    rd_chan = rd & hit(addr, `USD_OFS_CHAN);
    rd_rxh = rd & hit(addr, `USD_OFS_RXH);
    rd_nerr = rd & hit(addr, `USD_OFS_NERR);
    wr_txh = wr & hit(addr, `USD_OFS_TXH);

    // Two-stage synchronisers; only the second stage and its one-cycle-old copy are looked at.
    s_nxt.ln1 = {send_clear_line, carrier_line, set_ready_line, bell_line};
    s_nxt.ln2 = s_r.ln1;
    s_nxt.lnp = s_r.ln2;
    s_nxt.sck1 = sck_pin;
    s_nxt.sck2 = s_r.sck1;
    s_nxt.sckp = s_r.sck2;

    // Bits 1..3 of the line vector are set-ready, carrier, send-clear.
    toggles = s_r.ln2[3:1] ^ s_r.lnp[3:1];
    for (int i = 0; i < 3; i++)
    begin
      s_nxt.chg[i] = sticky(s_r.chg[i], toggles[i], rd_chan);
    end

    // Receive holding capture.
    if (rx_strobe)
    begin
      s_nxt.rx_chr = rx_char;
      s_nxt.rx_cmd = rx_is_command;
    end
    s_nxt.rx_has = sticky(s_r.rx_has, rx_strobe, rd_rxh);

    // Transmit holding; a write in the take cycle keeps the new
    // character pending so it is never lost.
    if (wr_txh)
    begin
      s_nxt.tx_chr = wdata[8:0];
      s_nxt.tx_cmd = wdata[`USD_CMD_BIT];
    end
    s_nxt.tx_pend = sticky(s_r.tx_pend, wr_txh, tx_take);

    // Configuration writes.
    if (wr)
    begin
      case (addr)
        ADDR_W'(`USD_OFS_MODE):
        begin
          s_nxt.mode = wdata[3:0];
        end
        ADDR_W'(`USD_OFS_BAUD):
        begin
          s_nxt.cd = wdata[15:0];
          s_nxt.fp = wdata[`USD_FP_LSB +: 3];
        end
        ADDR_W'(`USD_OFS_IDLE):
        begin
          s_nxt.to_lim = wdata[15:0];
        end
        ADDR_W'(`USD_OFS_GUARD):
        begin
          s_nxt.tg = wdata[7:0];
        end
        ADDR_W'(`USD_OFS_RATIO):
        begin
          s_nxt.ratio = wdata[10:0];
        end
        ADDR_W'(`USD_OFS_IRF):
        begin
          s_nxt.irf = wdata[7:0];
        end
        ADDR_W'(`USD_OFS_IEN):
        begin
          s_nxt.ien = wdata[4:0];
        end
        default:
        begin
          s_nxt.mode = s_r.mode;
        end
      endcase
    end

    // Divisor stage. In smart-card mode it counts rising edges of the
    // serial clock pin, otherwise every system clock.
    src_edge = s_r.mode[`USD_MODE_ISO] ? (s_r.sck2 & ~s_r.sckp) : 1'b1;
    div_end = src_edge && (s_r.div_cnt == 16'h0) && (s_r.cd != 16'h0);
    frac_sum = {1'b0, s_r.acc} + {1'b0, s_r.fp};
    s_nxt.os_tick = 1'b0;
    if (s_r.cd == 16'h0)
    begin
      s_nxt.div_cnt = 16'h0;
      s_nxt.acc = 3'h0;
    end
    else if (div_end)
    begin
      s_nxt.os_tick = 1'b1;
      // Each carry out of the eighths stretches one period by one counted edge: a system clock, or a serial clock rising edge in smart-card mode.
      s_nxt.acc = frac_sum[2:0];
      s_nxt.div_cnt = 16'(s_r.cd - 16'h1) + {15'h0, frac_sum[3]};
    end
    else if (src_edge)
    begin
      s_nxt.div_cnt = 16'(s_r.div_cnt - 16'h1);
    end

    // Bit stage.
    os_top = s_r.mode[`USD_MODE_OVER] ? `USD_OS8 : `USD_OS16;
    os_top_hit = s_r.os_cnt >= os_top;
    s_nxt.bit_tick = 1'b0;
    if (s_r.mode[`USD_MODE_ISO])
    begin
      s_nxt.os_cnt = 4'h0;
      if (s_r.ratio == 11'h0)
      begin
        s_nxt.rat_cnt = 11'h0;
      end
      else if (s_r.os_tick)
      begin
        if (s_r.rat_cnt >= 11'(s_r.ratio - 11'h1))
        begin
          s_nxt.rat_cnt = 11'h0;
          s_nxt.bit_tick = 1'b1;
        end
        else
        begin
          s_nxt.rat_cnt = 11'(s_r.rat_cnt + 11'h1);
        end
      end
    end
    else if (s_r.mode[`USD_MODE_SYNC])
    begin
      s_nxt.os_cnt = 4'h0;
      s_nxt.rat_cnt = 11'h0;
      s_nxt.bit_tick = s_r.os_tick;
    end
    else
    begin
      s_nxt.rat_cnt = 11'h0;
      if (s_r.os_tick)
      begin
        if (os_top_hit)
        begin
          s_nxt.os_cnt = 4'h0;
          s_nxt.bit_tick = 1'b1;
        end
        else
        begin
          s_nxt.os_cnt = 4'(s_r.os_cnt + 4'h1);
        end
      end
    end

    // Receiver time-out restarts on every character.
    to_hit = s_r.to_run && s_r.bit_tick &&
             (16'(s_r.to_cnt + 16'h1) == s_r.to_lim);
    if (rx_strobe)
    begin
      s_nxt.to_cnt = 16'h0;
      s_nxt.to_run = (s_r.to_lim != 16'h0);
    end
    else if (s_r.to_lim == 16'h0)
    begin
      s_nxt.to_run = 1'b0;
    end
    else if (to_hit)
    begin
      s_nxt.to_run = 1'b0;
      s_nxt.to_cnt = 16'h0;
    end
    else if (s_r.to_run && s_r.bit_tick)
    begin
      s_nxt.to_cnt = 16'(s_r.to_cnt + 16'h1);
    end

    // Timeguard holds the next start back for the programmed periods.
    if (tx_char_done)
    begin
      s_nxt.tg_cnt = s_r.tg;
    end
    else if (s_r.bit_tick && (s_r.tg_cnt != 8'h0))
    begin
      s_nxt.tg_cnt = 8'(s_r.tg_cnt - 8'h1);
    end

    // Error count saturates rather than wrapping to a misleading value.
    if (iso_error && s_r.mode[`USD_MODE_ISO])
    begin
      if (rd_nerr)
      begin
        s_nxt.nerr = 8'h1;
      end
      else if (s_r.nerr != 8'hff)
      begin
        s_nxt.nerr = 8'(s_r.nerr + 8'h1);
      end
    end
    else if (rd_nerr)
    begin
      s_nxt.nerr = 8'h0;
    end

    // Interrupt status: sticky, write-one-to-clear.
    events = '0;
    events[`USD_IRQ_RX] = rx_strobe;
    events[`USD_IRQ_TX] = tx_take;
    events[`USD_IRQ_TO] = to_hit;
    events[`USD_IRQ_CHG] = |toggles;
    events[`USD_IRQ_ERR] = iso_error & s_r.mode[`USD_MODE_ISO];
    for (int i = 0; i < 5; i++)
    begin
      s_nxt.ists[i] = sticky(s_r.ists[i], events[i],
                             wr && hit(addr, `USD_OFS_ICLR) && wdata[i]);
    end

    // Read data stand only in the cycle after the strobe.
    s_nxt.rdata = 32'h0;
    if (rd)
    begin
      case (addr)
        ADDR_W'(`USD_OFS_MODE):
        begin
          s_nxt.rdata[3:0] = s_r.mode;
        end
        ADDR_W'(`USD_OFS_CHAN):
        begin
          s_nxt.rdata[0] = s_r.rx_has;
          s_nxt.rdata[1] = tx_holding_free;
          s_nxt.rdata[`USD_TO_BIT] = s_r.ists[`USD_IRQ_TO];
          s_nxt.rdata[`USD_CHG_LSB +: 3] = s_r.chg;
          s_nxt.rdata[`USD_IMG_LSB +: 4] = s_r.ln2;
        end
        ADDR_W'(`USD_OFS_RXH):
        begin
          s_nxt.rdata[8:0] = s_r.rx_chr;
          s_nxt.rdata[`USD_CMD_BIT] = s_r.rx_cmd;
        end
        ADDR_W'(`USD_OFS_BAUD):
        begin
          s_nxt.rdata[15:0] = s_r.cd;
          s_nxt.rdata[`USD_FP_LSB +: 3] = s_r.fp;
        end
        ADDR_W'(`USD_OFS_IDLE):
        begin
          s_nxt.rdata[15:0] = s_r.to_lim;
        end
        ADDR_W'(`USD_OFS_GUARD):
        begin
          s_nxt.rdata[7:0] = s_r.tg;
        end
        ADDR_W'(`USD_OFS_RATIO):
        begin
          s_nxt.rdata[10:0] = s_r.ratio;
        end
        ADDR_W'(`USD_OFS_NERR):
        begin
          s_nxt.rdata[7:0] = s_r.nerr;
        end
        ADDR_W'(`USD_OFS_IRF):
        begin
          s_nxt.rdata[7:0] = s_r.irf;
        end
        ADDR_W'(`USD_OFS_ISTS):
        begin
          s_nxt.rdata[4:0] = s_r.ists;
        end
        ADDR_W'(`USD_OFS_IEN):
        begin
          s_nxt.rdata[4:0] = s_r.ien;
        end
        default:
        begin
          s_nxt.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.ratio <= `USD_RATIO_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign tx_char = s_r.tx_chr;
  assign tx_as_command = s_r.tx_cmd;
  // A disabled transmitter reports no free holding slot.
  assign tx_holding_free = s_r.mode[`USD_MODE_TXEN] & ~s_r.tx_pend;
  assign guard_active = (s_r.tg_cnt != 8'h0);
  // A character finishing now starts the guard, so the next one waits too.
  assign tx_go = s_r.tx_pend & s_r.mode[`USD_MODE_TXEN] & ~guard_active &
                 ~(tx_char_done & (s_r.tg != 8'h0));
  assign rx_has_char = s_r.rx_has;
  assign rx_timeout = s_r.ists[`USD_IRQ_TO];
  assign sample_tick = s_r.os_tick;
  assign bit_tick = s_r.bit_tick;
  assign ir_filter = s_r.irf;
  assign irq = |(s_r.ists & s_r.ien);

endmodule
